// [logic/byte_port_device.sv]
`timescale 1ns/10ps
`include "byte_port_regs.svh"
module byte_port_device
  import byte_port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  byte_port_link.device    link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  analog_enable
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  data_out_q, data_out_d;
  logic [7:0]  data_in_q, data_in_d;
  logic [7:0]  wr_data_q, wr_data_d;
  logic [7:0]  dir_q, dir_d;
  logic        in_full_q, in_full_d;
  logic        out_full_q, out_full_d;
  logic        overrun_q, overrun_d;
  logic        sel_q, sel_d;
  logic [2:0]  cdir_q, cdir_d;
  logic [2:0]  clatch_q, clatch_d;
  logic [2:0]  analog_q, analog_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0]  byte_oe_q, byte_oe_d;
  logic [7:0]  byte_out_q, byte_out_d;
  logic [2:0]  ctrl_oe_q, ctrl_oe_d;
  logic [2:0]  ctrl_out_q, ctrl_out_d;

  logic [2:0]  ctrl_dig;
  logic        cs_act;
  logic        wr_lvl;
  logic        rd_lvl;
  logic        wr_end;
  logic        rd_start;
  logic [7:0]  idx;
  logic        mapped;
  logic        done_x;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  read_byte;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  assign ctrl_dig = digital_view(link.ctrl_level, analog_q); // RULE6
  assign cs_act   = sel_q & ~ctrl_dig[`CS_PIN];              // RULE12
  assign wr_lvl   = cs_act & ~ctrl_dig[`WR_PIN];             // RULE11
  assign rd_lvl   = cs_act & ~ctrl_dig[`RD_PIN];             // RULE10

  strobe_edge u_wr_edge (
    .clock  (clock),
    .rst_b  (rst_b),
    .level  (wr_lvl),
    .start  (),
    .finish (wr_end)
  );

  strobe_edge u_rd_edge (
    .clock  (clock),
    .rst_b  (rst_b),
    .level  (rd_lvl),
    .start  (rd_start),
    .finish ()
  );

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  assign idx    = paddr[`IDX_MSB:`IDX_LSB];
  assign done_x = psel & penable & pready_q;
  assign wr_go  = done_x & pwrite & mapped;
  assign rd_go  = done_x & ~pwrite & mapped;

  always_comb
  begin
    mapped    = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    read_byte = 8'h00;
    unique case (idx)
      `DATA_IDX:   read_byte = sel_q ? data_in_q : link.byte_level; // RULE1
      `DIR_IDX:    read_byte = dir_q;
      `CTRL_IDX:   read_byte = {in_full_q, out_full_q, overrun_q, sel_q,
                                1'b0, cdir_q};                     // RULE17
      `PINS_IDX:   read_byte = {5'h00, ctrl_dig};                   // RULE6
      `ANALOG_IDX: read_byte = {5'h00, analog_q};
      default:     mapped = 1'b0;
    endcase
    // Refused accesses read zero, even on a known index
    if (!mapped)
      read_byte = 8'h00;
  end

  always_comb
  begin
    pready_d   = psel & penable & ~pready_q;
    pslverr_d  = 1'b0;
    prdata_d   = prdata_q;
    data_out_d = data_out_q;
    data_in_d  = data_in_q;
    dir_d      = dir_q;
    in_full_d  = in_full_q;
    out_full_d = out_full_q;
    overrun_d  = overrun_q;
    sel_d      = sel_q;
    cdir_d     = cdir_q;
    clatch_d   = clatch_q;
    analog_d   = analog_q;
    // Sample the bus every cycle of the strobe; the last one counts
    wr_data_d  = wr_lvl ? link.byte_level : wr_data_q;
    if (pready_d)
    begin
      prdata_d  = {24'h000000, read_byte};
      pslverr_d = ~mapped;
    end
    if (rd_go && idx == `DATA_IDX)
      in_full_d = 1'b0;                                            // RULE13
    if (wr_go)
    begin
      unique case (idx)
        `DATA_IDX:   data_out_d = pwdata[7:0];
        `DIR_IDX:    dir_d      = pwdata[7:0];
        `PINS_IDX:   clatch_d   = pwdata[2:0];
        `ANALOG_IDX: analog_d   = pwdata[2:0];                     // RULE5
        `CTRL_IDX:
        begin
          overrun_d = pwdata[`OVERRUN_BIT];                        // RULE15
          sel_d  = pwdata[`SEL_BIT];                               // RULE3
          cdir_d = pwdata[2:0];                                    // RULE9
        end
        default:     data_out_d = data_out_q;
      endcase
    end
    if (rd_start)
      out_full_d = 1'b0;                                           // RULE14
    if (wr_go && idx == `DATA_IDX && sel_q)
      out_full_d = 1'b1;                                           // RULE14
    if (wr_end)
    begin
      // An unread byte is kept; the new one is dropped as overflow
      if (in_full_q)
        overrun_d = 1'b1;                                          // RULE15
      else
        data_in_d = wr_data_q;                                     // RULE11
      in_full_d = 1'b1;                                            // RULE13
    end
    if (!sel_q)
    begin
      in_full_d  = 1'b0;                                           // RULE16
      out_full_d = 1'b0;                                           // RULE16
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h00000000;
      data_out_q <= `DATA_RESET;
      data_in_q  <= `DATA_RESET;
      wr_data_q  <= `DATA_RESET;
      dir_q      <= `DIR_RESET;
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
      overrun_q  <= 1'b0;
      sel_q      <= 1'b0;
      cdir_q     <= `CDIR_RESET;                                   // RULE9
      clatch_q   <= `CLATCH_RESET;
      analog_q   <= `ANALOG_RESET;                                 // RULE8
    end
    else
    begin
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      data_out_q <= data_out_d;
      data_in_q  <= data_in_d;
      wr_data_q  <= wr_data_d;
      dir_q      <= dir_d;
      in_full_q  <= in_full_d;
      out_full_q <= out_full_d;
      overrun_q  <= overrun_d;
      sel_q      <= sel_d;
      cdir_q     <= cdir_d;
      clatch_q   <= clatch_d;
      analog_q   <= analog_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_comb
  begin
    byte_out_d = data_out_q;
    ctrl_out_d = clatch_q;
    if (sel_q)
    begin
      // Byte direction ignored: the far end steers the data flow
      byte_oe_d = rd_lvl ? 8'hff : 8'h00;                          // RULE10
      ctrl_oe_d = 3'h0;                                            // RULE3
    end
    else
    begin
      byte_oe_d = ~dir_q;                                          // RULE1
      // Analog pins still follow direction; software keeps them in
      ctrl_oe_d = ~cdir_q;                                         // RULE7
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      byte_oe_q  <= 8'h00;
      byte_out_q <= `DATA_RESET;
      ctrl_oe_q  <= 3'h0;
      ctrl_out_q <= `CLATCH_RESET;
    end
    else
    begin
      byte_oe_q  <= byte_oe_d;
      byte_out_q <= byte_out_d;
      ctrl_oe_q  <= ctrl_oe_d;                                     // RULE2
      ctrl_out_q <= ctrl_out_d;
    end
  end

  assign link.dev_data    = byte_out_q;
  assign link.dev_data_oe = byte_oe_q;
  assign link.dev_ctrl    = ctrl_out_q;
  assign link.dev_ctrl_oe = ctrl_oe_q;
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign analog_enable    = analog_q;                              // RULE5
endmodule // byte_port_device

// [logic/byte_port_host.sv]
`timescale 1ns/10ps
`include "byte_port_regs.svh"
module byte_port_host
  import byte_port_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  byte_port_link.host     link,
  input  wire logic       req,
  input  wire logic       req_write,
  input  wire logic [7:0] req_data,
  output logic            busy,
  output logic            done,
  output logic      [7:0] rdata
);
  host_state_t   state_q, state_d;
  strobe_count_t cnt_q, cnt_d;
  logic          write_q, write_d;
  logic [7:0]    wdata_q, wdata_d;
  logic          cs_n_q, cs_n_d;
  logic          rd_n_q, rd_n_d;
  logic          wr_n_q, wr_n_d;
  logic          data_oe_q, data_oe_d;
  logic          ctrl_oe_q, ctrl_oe_d;
  logic          busy_q, busy_d;
  logic          done_q, done_d;
  logic [7:0]    rdata_q, rdata_d;

  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    write_d   = write_q;
    wdata_d   = wdata_q;
    cs_n_d    = cs_n_q;
    rd_n_d    = rd_n_q;
    wr_n_d    = wr_n_q;
    data_oe_d = data_oe_q;
    ctrl_oe_d = 1'b1;
    busy_d    = busy_q;
    done_d    = 1'b0;
    rdata_d   = rdata_q;
    unique case (state_q)
      H_IDLE:
        if (req)
        begin
          state_d   = H_STROBE;
          cnt_d     = strobe_count_t'(`STROBE_CYCLES - 1);
          write_d   = req_write;
          wdata_d   = req_data;
          cs_n_d    = 1'b0;                                        // RULE12
          wr_n_d    = ~req_write;                                  // RULE11
          rd_n_d    = req_write;                                   // RULE10
          data_oe_d = req_write;
          busy_d    = 1'b1;
        end
      H_STROBE:
        if (cnt_q == 4'h0)
        begin
          // Late sample leaves the device time to turn the bus round
          if (!write_q)
            rdata_d = link.byte_level;                             // RULE10
          cs_n_d    = 1'b1;
          wr_n_d    = 1'b1;
          rd_n_d    = 1'b1;
          data_oe_d = 1'b0;
          state_d   = H_GAP;
          cnt_d     = strobe_count_t'(`GAP_CYCLES - 1);
        end
        else
          cnt_d = cnt_q - 4'h1;
      H_GAP:
        if (cnt_q == 4'h0)
        begin
          state_d = H_IDLE;
          busy_d  = 1'b0;
          done_d  = 1'b1;
        end
        else
          cnt_d = cnt_q - 4'h1;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q   <= H_IDLE;
      cnt_q     <= 4'h0;
      write_q   <= 1'b0;
      wdata_q   <= 8'h00;
      cs_n_q    <= 1'b1;
      rd_n_q    <= 1'b1;
      wr_n_q    <= 1'b1;
      data_oe_q <= 1'b0;
      ctrl_oe_q <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      write_q   <= write_d;
      wdata_q   <= wdata_d;
      cs_n_q    <= cs_n_d;
      rd_n_q    <= rd_n_d;
      wr_n_q    <= wr_n_d;
      data_oe_q <= data_oe_d;
      ctrl_oe_q <= ctrl_oe_d;
      busy_q    <= busy_d;
      done_q    <= done_d;
      rdata_q   <= rdata_d;
    end
  end

  assign link.host_data    = wdata_q;
  assign link.host_data_oe = data_oe_q;
  assign link.host_ctrl    = {cs_n_q, wr_n_q, rd_n_q};
  assign link.host_ctrl_oe = {3{ctrl_oe_q}};
  assign busy              = busy_q;
  assign done              = done_q;
  assign rdata             = rdata_q;
endmodule // byte_port_host

// [logic/strobe_edge.sv]
`timescale 1ns/10ps
module strobe_edge (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic level,
  output logic      start,
  output logic      finish
);
  logic level_q;
  logic level_d;

  always_comb
  begin
    level_d = level;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      level_q <= 1'b0;
    else
      level_q <= level_d;
  end

  // Edge detected: a strobe ends when either qualifying line rises
  assign start  = level & ~level_q;
  assign finish = ~level & level_q;
endmodule // strobe_edge

// [shared/byte_port_link.sv]
`timescale 1ns/10ps
interface byte_port_link;
  logic [7:0] dev_data;
  logic [7:0] dev_data_oe;
  logic [2:0] dev_ctrl;
  logic [2:0] dev_ctrl_oe;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [2:0] host_ctrl;
  logic [2:0] host_ctrl_oe;
  logic [7:0] byte_level;
  logic [2:0] ctrl_level;

  // ----------------------------------------------------------------
  // Wire levels; undriven pins float high through pull-ups
  // ----------------------------------------------------------------
  assign byte_level = (dev_data & dev_data_oe)
                    | (host_data & {8{host_data_oe}} & ~dev_data_oe)
                    | ~(dev_data_oe | {8{host_data_oe}});
  assign ctrl_level = (dev_ctrl & dev_ctrl_oe)
                    | (host_ctrl & host_ctrl_oe & ~dev_ctrl_oe)
                    | ~(dev_ctrl_oe | host_ctrl_oe);

  modport device (
    output dev_data,
    output dev_data_oe,
    output dev_ctrl,
    output dev_ctrl_oe,
    input  byte_level,
    input  ctrl_level
  );

  modport host (
    output host_data,
    output host_data_oe,
    output host_ctrl,
    output host_ctrl_oe,
    input  byte_level
  );
endinterface // byte_port_link

// [shared/byte_port_pkg.sv]
package byte_port_pkg;

  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_GAP} host_state_t;

  typedef logic [3:0] strobe_count_t;

  // Pins set to analog give a zero to every digital reader
  function automatic logic [2:0] digital_view(input logic [2:0] level,
                                              input logic [2:0] analog);
    digital_view = level & ~analog;
  endfunction

endpackage

// [shared/byte_port_regs.svh]
`ifndef BYTE_PORT_REGS_SVH
`define BYTE_PORT_REGS_SVH
// Notes on behaviour
// RULE1 - Byte pins are general I/O or slave data
// RULE2 - Three control pins, each input or output
// RULE3 - Slave select turns control pins into strobes
// RULE4 - Software sets strobe pins digital inputs first
// RULE5 - Each control pin can be analog input
// RULE6 - Analog control pin reads back as zero
// RULE7 - Direction bits still drive analog pins
// RULE8 - Control pins come up analog after reset
// RULE9 - Direction bits 2..0: one input, reset one
// RULE10 - Low read strobe while selected reads byte
// RULE11 - Low write strobe while selected writes byte
// RULE12 - Chip select low selects; strobes need it
// RULE13 - Input full set at write end, read clears
// RULE14 - Output full clears at read start
// RULE15 - Overflow on second unread write; software clears
// RULE16 - Full flags held clear outside slave mode
// RULE17 - Direction bit 3 reads zero, ignores writes

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define IDX_MSB         9
`define IDX_LSB         2
`define DATA_IDX        8'h08
`define PINS_IDX        8'h09
`define DIR_IDX         8'h88
`define CTRL_IDX        8'h89
`define ANALOG_IDX      8'h9f

// ----------------------------------------------------------------
// Fields of the control-port direction and status register
// ----------------------------------------------------------------
`define IN_FULL_BIT     7
`define OUT_FULL_BIT    6
`define OVERRUN_BIT     5
`define SEL_BIT         4
`define CS_PIN          2
`define WR_PIN          1
`define RD_PIN          0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DATA_RESET      8'h00
`define DIR_RESET       8'hff
`define CDIR_RESET      3'h7
`define ANALOG_RESET    3'h7
`define CLATCH_RESET    3'h0

// ----------------------------------------------------------------
// Timing of the far-end strobes
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS 4
`define STROBE_NS       32
`define GAP_NS          8
`define STROBE_CYCLES   ((`STROBE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define GAP_CYCLES      ((`GAP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// [sim/byte_port_monitor.sv]
`timescale 1ns/10ps
module byte_port_monitor (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [7:0] dev_data,
  input wire logic [7:0] dev_data_oe,
  input wire logic [2:0] dev_ctrl_oe,
  input wire logic [2:0] host_ctrl,
  input wire logic [2:0] host_ctrl_oe,
  input wire logic       host_data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic cs_on;
  logic rd_on;
  logic wr_on;
  assign cs_on = host_ctrl_oe[2] && !host_ctrl[2];
  assign rd_on = cs_on && !host_ctrl[0];
  assign wr_on = cs_on && !host_ctrl[1];

  // ----------------------------------------
  // Frame steps on the strobe lines
  // ----------------------------------------
  sequence s_sel_start; !cs_on ##1 cs_on; endsequence
  sequence s_sel_end;   cs_on ##1 !cs_on; endsequence
  sequence s_rd_start;  !rd_on ##1 rd_on; endsequence
  sequence s_rd_end;    rd_on ##1 !rd_on; endsequence

  property p_strobe_cs;
    (host_ctrl_oe[0] && !host_ctrl[0]) || (host_ctrl_oe[1] && !host_ctrl[1])
      |-> cs_on;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs)
    else $error("strobe active without select");
  property p_one_strobe;
    cs_on |-> host_ctrl[1:0] == 2'b01 || host_ctrl[1:0] == 2'b10;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("select without exactly one strobe");
  property p_len; s_sel_start |=> cs_on [*7] ##1 !cs_on; endproperty
  a_len: assert property (p_len)
    else $error("strobe frame length wrong");
  property p_gap; s_sel_end |=> !cs_on; endproperty
  a_gap: assert property (p_gap)
    else $error("gap between frames too short");
  property p_rd_drive; s_rd_start |=> dev_data_oe == 8'hff; endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("device late driving read byte");
  property p_rd_release;
    s_rd_end |-> dev_data_oe == 8'hff ##1 dev_data_oe == 8'h00;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("device read drive release wrong");
  property p_rd_stable;
    rd_on && $past(rd_on) && dev_data_oe == 8'hff
      && $past(dev_data_oe) == 8'hff |-> $stable(dev_data);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("read byte changed during strobe");
  property p_wr_nodrive; wr_on |-> dev_data_oe == 8'h00; endproperty
  a_wr_nodrive: assert property (p_wr_nodrive)
    else $error("device drives bus during external write");
  property p_wr_data; wr_on |-> host_data_oe; endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write strobe without host data on the bus");
  property p_ctrl_in; cs_on |-> dev_ctrl_oe == 3'b000; endproperty
  a_ctrl_in: assert property (p_ctrl_in)
    else $error("device drives control pins in slave use");
endmodule // byte_port_monitor

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
  localparam logic [11:0] A_DATA = 12'h020;
  localparam logic [11:0] A_PINS = 12'h024;
  localparam logic [11:0] A_DIR  = 12'h220;
  localparam logic [11:0] A_CTRL = 12'h224;
  localparam logic [11:0] A_ANA  = 12'h27c;
  localparam logic [11:0] A_BAD  = 12'h100;
  logic        clock     = 1'b0;
  logic        rst_b     = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic        req       = 1'b0;
  logic        req_write = 1'b0;
  logic [7:0]  req_data  = 8'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, busy, done;
  logic [2:0]  analog_enable;
  logic [7:0]  rdata, b1, b2, e;
  integer      num_errors = 0;
  integer      checked = 0;
  integer      seed = 32'h87e246f2;
  integer      i;

  always #2 clock = ~clock;

  byte_port_link link ();
  byte_port_device byte_port_device_i (.clock(clock), .rst_b(rst_b),
    .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_enable(analog_enable));
  byte_port_host byte_port_host_i (.clock(clock), .rst_b(rst_b),
    .link(link), .req(req), .req_write(req_write), .req_data(req_data),
    .busy(busy), .done(done), .rdata(rdata));
  byte_port_monitor byte_port_monitor_i (.clock(clock), .rst_b(rst_b),
    .dev_data(link.dev_data), .dev_data_oe(link.dev_data_oe),
    .dev_ctrl_oe(link.dev_ctrl_oe), .host_ctrl(link.host_ctrl),
    .host_ctrl_oe(link.host_ctrl_oe), .host_data_oe(link.host_data_oe));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    num_errors++;
    $display("wrong value at %0t: no answer", $time);
    close_out;
  endtask

  // Request held until pready is seen high at a rising edge; data taken
  // at that same edge, then released; one idle cycle avoids a double drive
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    integer n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20) hang;
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, x});
  endtask

  task automatic xfer(input logic w, input logic [7:0] d);
    integer n;
    n = 0;
    req <= 1'b1;
    req_write <= w;
    req_data <= d;
    @(posedge clock);
    req <= 1'b0;
    @(posedge clock);
    chk({31'h0, busy}, 32'h1);
    while (done !== 1'b1)
    begin
      n++;
      if (n > 40) hang;
      @(posedge clock);
    end
    chk({31'h0, busy}, 32'h0);
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  // Undriven or input pins float high through the pull-ups
  function automatic logic [7:0] wire_lvl(input logic [7:0] d, dir);
    return (d & ~dir) | dir;
  endfunction

  function automatic logic [7:0] stat(input logic in_full, out_full,
                                      overrun);
    return {in_full, out_full, overrun, 5'h17};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rchk(A_DIR, 8'hff);
    rchk(A_CTRL, 8'h07);
    rchk(A_ANA, 8'h07);
    chk({29'h0, analog_enable}, 32'h7);
    rchk(A_PINS, 8'h00);
    wr(A_CTRL, 8'hef);
    rchk(A_CTRL, 8'h27);
    wr(A_CTRL, 8'h07);
    rchk(A_CTRL, 8'h07);
    rchk(A_BAD, 8'h00);
    chk({31'h0, err}, 32'h1);
    rchk(A_DATA + 12'h001, 8'h00);
    chk({31'h0, err}, 32'h1);
    fin("reset");
    for (i = 0; i < 8; i++)
    begin
      b1 = $random(seed);
      b2 = $random(seed);
      wr(A_CTRL, {5'h0, b2[5:3]});
      wr(A_ANA, {5'h0, b2[2:0]});
      wr(A_PINS, {5'h0, b1[2:0]});
      e = wire_lvl({5'h0, b1[2:0]}, {5'h1f, b2[5:3]});
      rchk(A_PINS, {5'h0, e[2:0] & ~b2[2:0]});
      chk({29'h0, link.ctrl_level}, {29'h0, e[2:0]});
      chk({29'h0, analog_enable}, {29'h0, b2[2:0]});
    end
    wr(A_CTRL, 8'h07);
    wr(A_ANA, 8'h00);
    fin("control pins");
    for (i = 0; i < 8; i++)
    begin
      b1 = $random(seed);
      b2 = (i == 0) ? 8'h00 : $random(seed);
      wr(A_DIR, b2);
      wr(A_DATA, b1);
      rchk(A_DATA, wire_lvl(b1, b2));
      chk({24'h0, link.byte_level}, {24'h0, wire_lvl(b1, b2)});
    end
    wr(A_DIR, 8'hff);
    xfer(1'b1, 8'h5a);
    rchk(A_CTRL, 8'h07);
    rchk(A_DATA, 8'hff);
    fin("byte port");
    b1 = $random(seed);
    b2 = $random(seed);
    wr(A_CTRL, 8'h17);
    xfer(1'b1, b1);
    rchk(A_CTRL, stat(1'b1, 1'b0, 1'b0));
    xfer(1'b1, b2);
    rchk(A_CTRL, stat(1'b1, 1'b0, 1'b1));
    rchk(A_DATA, b1);
    rchk(A_CTRL, stat(1'b0, 1'b0, 1'b1));
    wr(A_CTRL, 8'h17);
    rchk(A_CTRL, stat(1'b0, 1'b0, 1'b0));
    wr(A_DATA, b2);
    rchk(A_CTRL, stat(1'b0, 1'b1, 1'b0));
    xfer(1'b0, 8'h00);
    chk({24'h0, rdata}, {24'h0, b2});
    rchk(A_CTRL, stat(1'b0, 1'b0, 1'b0));
    xfer(1'b1, b1);
    wr(A_CTRL, 8'h07);
    rchk(A_CTRL, 8'h07);
    fin("slave port");
    wr(A_CTRL, 8'h20);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rchk(A_ANA, 8'h07);
    rchk(A_CTRL, 8'h07);
    fin("second reset");
    close_out;
  end
endmodule // testbench
